// [common/apm_pkg.sv]
// Constants for the process image mapper: image geometry, assembly ids and lengths.
// Assumes one 125 MHz clock and images streamed as bytes or 16-bit words, low byte first.
//
// Summary of operation
// - Single network maps slaves 1-31 A and B
// - Second network repeats layout at bytes 32-63
// - Byte 0 flags high, slave 1 low
// - Output image: byte 0 high unused, 16 reserved
// - Word n holds 4n+2,4n+3,4n,4n+1
// - Output words 8-15 carry B slaves
// - Connection type selects returned data set
package apm_pkg;
  localparam int unsigned APM_NETS = 2;
  localparam int unsigned APM_SLOTS = 32;
  localparam logic [5:0] APM_NET_BYTES = 6'h20;
  localparam logic [4:0] APM_B_FIRST = 5'h10;
  localparam logic [5:0] APM_LAST_SINGLE = 6'h1f;
  localparam logic [5:0] APM_LAST_DUAL = 6'h3f;
  localparam int unsigned APM_RPI_MIN_MS = 10;
  // Assembly instance ids
  localparam logic [7:0] APM_ASM_OUT_DIG = 8'h64;
  localparam logic [7:0] APM_ASM_OUT_AIO = 8'h66;
  localparam logic [7:0] APM_ASM_IN_DIG = 8'h65;
  localparam logic [7:0] APM_ASM_IN_DIAG = 8'h67;
  localparam logic [7:0] APM_ASM_IN_AIO = 8'h69;
  // Assembly lengths in bytes, single network; dual doubles them
  localparam logic [8:0] APM_LEN_DIG = 9'h020;
  localparam logic [8:0] APM_LEN_IN_DIAG = 9'h042;
  localparam logic [8:0] APM_LEN_IN_AIO = 9'h06a;
  localparam logic [8:0] APM_LEN_OUT_AIO = 9'h048;
  typedef enum logic [1:0] {APM_CONN_DIG, APM_CONN_DIAG, APM_CONN_AIO} apm_conn_t;
  typedef enum logic {APM_IDLE, APM_SEND} apm_state_t;
endpackage

// [core/apm_buf2.sv]
// Two-entry buffer between the image sequencer and the controller side.
// Assumes a single clock; the head entry drives the outputs straight from flops.
`timescale 1ns/100ps
module apm_buf2 #(
  parameter int unsigned WIDTH = 17
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic push_in,
  input wire logic [WIDTH-1:0] push_data_in,
  output logic push_ready_out,
  output logic pop_valid_out,
  output logic [WIDTH-1:0] pop_data_out,
  input wire logic pop_ready_in
);
  logic [WIDTH-1:0] spare_reg;
  logic [1:0] cnt_reg;
  logic [1:0] cnt_next;
  wire do_push = push_in && (cnt_reg != 2'h2);
  wire do_pop = (cnt_reg != 2'h0) && pop_ready_in;

  assign cnt_next = cnt_reg + {1'b0, do_push} - {1'b0, do_pop};
  assign push_ready_out = (cnt_reg != 2'h2);

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_reg <= 2'h0;
      pop_valid_out <= 1'b0;
      pop_data_out <= '0;
      spare_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
      pop_valid_out <= (cnt_next != 2'h0);
      if (do_push && ((cnt_reg == 2'h0) || (cnt_reg == 2'h1 && do_pop))) begin
        pop_data_out <= push_data_in;
      end else if (do_pop) begin
        pop_data_out <= spare_reg;
      end
      if (do_push && !(cnt_reg == 2'h0) && !(cnt_reg == 2'h1 && do_pop)) begin
        spare_reg <= push_data_in;
      end
    end
  end

  AST_HOLD_ON_STALL: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    pop_valid_out && !pop_ready_in |=> pop_valid_out && $stable(pop_data_out))
    else $error("buffer head changed while stalled");
endmodule // apm_buf2

// [core/apm_image_mapper.sv]
// Packs slave nibbles into the cyclic input image and unpacks the output image.
// Assumes slave arrays indexed by address, slot 0 unused, and images streamed low byte first.
`timescale 1ns/100ps
module apm_image_mapper
  import apm_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic dual_net_in,
  input wire logic word_fmt_in,
  input wire logic [1:0] conn_type_in,
  input wire logic frame_start_in,
  input wire logic [3:0] gw_flags_in [0:1],
  input wire logic [3:0] slave_in_a_in [0:1][0:31],
  input wire logic [3:0] slave_in_b_in [0:1][0:31],
  output logic tx_valid_out,
  output logic [15:0] tx_data_out,
  output logic tx_last_out,
  input wire logic tx_ready_in,
  input wire logic rx_valid_in,
  input wire logic [15:0] rx_data_in,
  input wire logic rx_last_in,
  output logic rx_ready_out,
  output logic [3:0] slave_out_a_out [0:1][0:31],
  output logic [3:0] slave_out_b_out [0:1][0:31],
  output logic [8:0] in_len_out,
  output logic [8:0] out_len_out,
  output logic [7:0] in_asm_out,
  output logic [7:0] out_asm_out
);
  // ************************************************************
  // Length decode
  // ************************************************************
  function automatic logic [8:0] len_of(input logic [1:0] conn, input logic dual, input logic is_in);
    logic [8:0] l;
    l = APM_LEN_DIG;
    unique case (conn)
      APM_CONN_DIAG: l = is_in ? APM_LEN_IN_DIAG : APM_LEN_DIG;
      APM_CONN_AIO: l = is_in ? APM_LEN_IN_AIO : APM_LEN_OUT_AIO;
      default: l = APM_LEN_DIG;
    endcase
    return dual ? {l[7:0], 1'b0} : l;
  endfunction

  apm_state_t state_reg;
  logic [5:0] tx_idx_reg;
  logic dual_reg;
  logic word_reg;
  logic [5:0] rx_idx_reg;
  logic [7:0] img [0:63];

  // ************************************************************
  // Input image layout
  // ************************************************************
  genvar n, b;
  generate
    for (n = 0; n < APM_NETS; n++) begin : g_net
      for (b = 0; b < 16; b++) begin : g_a
        if (b == 0) begin : g_flag
          assign img[n*32+b] = {gw_flags_in[n], slave_in_a_in[n][1]};
        end else begin : g_pair
          assign img[n*32+b] = {slave_in_a_in[n][2*b], slave_in_a_in[n][2*b+1]};
        end
      end
      for (b = 16; b < 32; b++) begin : g_b
        if (b == 16) begin : g_resv
          assign img[n*32+b] = {4'h0, slave_in_b_in[n][1]};
        end else begin : g_pair
          assign img[n*32+b] = {slave_in_b_in[n][2*(b-16)], slave_in_b_in[n][2*(b-16)+1]};
        end
      end
    end
  endgenerate

  // ************************************************************
  // Input image sequencer
  // ************************************************************
  logic buf_ready;
  wire push = (state_reg == APM_SEND);
  wire [5:0] last_idx = dual_reg ? APM_LAST_DUAL : APM_LAST_SINGLE;
  wire [5:0] hi_idx = tx_idx_reg + 6'h01;
  wire [15:0] beat = word_reg ? {img[hi_idx], img[tx_idx_reg]} : {8'h00, img[tx_idx_reg]};
  wire [5:0] beat_end = word_reg ? hi_idx : tx_idx_reg;
  wire beat_last = (beat_end == last_idx);
  wire beat_go = push && buf_ready;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_reg <= APM_IDLE;
      tx_idx_reg <= 6'h00;
      dual_reg <= 1'b0;
      word_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        APM_IDLE: if (frame_start_in) begin
          state_reg <= APM_SEND;
          tx_idx_reg <= 6'h00;
          dual_reg <= dual_net_in;
          word_reg <= word_fmt_in;
        end
        APM_SEND: if (buf_ready) begin
          tx_idx_reg <= beat_end + 6'h01;
          if (beat_last) begin
            state_reg <= APM_IDLE;
          end
        end
      endcase
    end
  end

  apm_buf2 #(.WIDTH(17)) u_buf (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .push_in(push),
    .push_data_in({beat_last, beat}),
    .push_ready_out(buf_ready),
    .pop_valid_out(tx_valid_out),
    .pop_data_out({tx_last_out, tx_data_out}),
    .pop_ready_in(tx_ready_in)
  );

  // ************************************************************
  // Connection type and assembly selection
  // ************************************************************
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      in_len_out <= APM_LEN_DIG;
      out_len_out <= APM_LEN_DIG;
      in_asm_out <= APM_ASM_IN_DIG;
      out_asm_out <= APM_ASM_OUT_DIG;
    end else if (state_reg == APM_IDLE && frame_start_in) begin
      in_len_out <= len_of(conn_type_in, dual_net_in, 1'b1);
      out_len_out <= len_of(conn_type_in, dual_net_in, 1'b0);
      in_asm_out <= (conn_type_in == APM_CONN_DIAG) ? APM_ASM_IN_DIAG :
                    (conn_type_in == APM_CONN_AIO) ? APM_ASM_IN_AIO : APM_ASM_IN_DIG;
      out_asm_out <= (conn_type_in == APM_CONN_AIO) ? APM_ASM_OUT_AIO : APM_ASM_OUT_DIG;
    end
  end

  // ************************************************************
  // Output image unpacking
  // ************************************************************
  wire rx_take = rx_valid_in && rx_ready_out;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rx_idx_reg <= 6'h00;
      rx_ready_out <= 1'b0;
    end else begin
      rx_ready_out <= 1'b1;
      if (rx_take) begin
        rx_idx_reg <= rx_last_in ? 6'h00 : rx_idx_reg + (word_fmt_in ? 6'h02 : 6'h01);
      end
    end
  end

  generate
    for (n = 0; n < APM_NETS; n++) begin : g_rx_net
      for (b = 0; b < 32; b++) begin : g_rx_byte
        localparam logic [5:0] IDX = 6'(n*32+b);
        wire hit_lo = rx_take && (rx_idx_reg == IDX);
        wire hit_hi = rx_take && word_fmt_in && (rx_idx_reg + 6'h01 == IDX);
        wire [7:0] d = hit_hi ? rx_data_in[15:8] : rx_data_in[7:0];
        wire we = hit_lo || hit_hi;
        if (b == 0) begin : g_slot0
          always_ff @(posedge clk_in or negedge rst_b_in) begin
            if (!rst_b_in) begin
              slave_out_a_out[n][0] <= 4'h0;
              slave_out_b_out[n][0] <= 4'h0;
              slave_out_a_out[n][1] <= 4'h0;
            end else if (we) begin
              slave_out_a_out[n][1] <= d[3:0];
            end
          end
        end else if (b < 16) begin : g_a
          always_ff @(posedge clk_in or negedge rst_b_in) begin
            if (!rst_b_in) begin
              slave_out_a_out[n][2*b] <= 4'h0;
              slave_out_a_out[n][2*b+1] <= 4'h0;
            end else if (we) begin
              slave_out_a_out[n][2*b] <= d[7:4];
              slave_out_a_out[n][2*b+1] <= d[3:0];
            end
          end
        end else if (b == 16) begin : g_b1
          always_ff @(posedge clk_in or negedge rst_b_in) begin
            if (!rst_b_in) begin
              slave_out_b_out[n][1] <= 4'h0;
            end else if (we) begin
              slave_out_b_out[n][1] <= d[3:0];
            end
          end
        end else begin : g_b
          always_ff @(posedge clk_in or negedge rst_b_in) begin
            if (!rst_b_in) begin
              slave_out_b_out[n][2*(b-16)] <= 4'h0;
              slave_out_b_out[n][2*(b-16)+1] <= 4'h0;
            end else if (we) begin
              slave_out_b_out[n][2*(b-16)] <= d[7:4];
              slave_out_b_out[n][2*(b-16)+1] <= d[3:0];
            end
          end
        end
      end
    end
  endgenerate

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  AST_FLAG_BYTE0: assert property (beat_go && tx_idx_reg == 6'h00 && !word_reg |->
    beat[7:4] == gw_flags_in[0] && beat[3:0] == slave_in_a_in[0][1])
    else $error("byte 0 does not hold flags and slave 1");
  AST_SINGLE_END: assert property (beat_go && !dual_reg |-> beat_end <= 6'h1f)
    else $error("single network image runs past byte 31");
  AST_DUAL_FLAG: assert property (beat_go && tx_idx_reg == 6'h20 |->
    beat[7:4] == gw_flags_in[1] && dual_reg)
    else $error("network 2 flag nibble misplaced");
  AST_RESV_ZERO: assert property (beat_go && tx_idx_reg[4:0] == 5'h10 |-> beat[7:4] == 4'h0)
    else $error("reserved input nibble not zero");
  AST_WORD_ORDER: assert property (beat_go && word_reg && tx_idx_reg == 6'h02 |->
    beat[15:12] == slave_in_a_in[0][6] && beat[11:8] == slave_in_a_in[0][7] &&
    beat[7:4] == slave_in_a_in[0][4] && beat[3:0] == slave_in_a_in[0][5])
    else $error("word 1 nibble order wrong");
  AST_RX_B_WORD: assert property (rx_take && word_fmt_in && !rx_last_in && rx_idx_reg == 6'h10 |=>
    slave_out_b_out[0][1] == $past(rx_data_in[3:0]) && slave_out_b_out[0][2] == $past(rx_data_in[15:12]))
    else $error("output word 8 not unpacked");
  AST_RX_BYTE1: assert property (rx_take && !word_fmt_in && rx_idx_reg == 6'h01 |=>
    slave_out_a_out[0][2] == $past(rx_data_in[7:4]) && slave_out_a_out[0][3] == $past(rx_data_in[3:0]))
    else $error("output byte 1 not unpacked");
  AST_CONN_LEN: assert property (state_reg == APM_IDLE && frame_start_in && conn_type_in == 2'h1 &&
    !dual_net_in |=> in_len_out == 9'h042 && in_asm_out == 8'h67)
    else $error("diagnostic connection length wrong");
  AST_SEND_BOUND: assert property ($rose(state_reg == APM_SEND) && !dual_reg && !word_reg ##0
    tx_ready_in [*8] |-> state_reg == APM_SEND)
    else $error("single frame ended early");

  CVR_SINGLE_BYTE: cover property (beat_go && beat_last && !dual_reg && !word_reg);
  CVR_DUAL_WORD: cover property (beat_go && beat_last && dual_reg && word_reg);
  CVR_STALL: cover property (tx_valid_out && !tx_ready_in ##1 !buf_ready);
  CVR_RX_LAST: cover property (rx_take && rx_last_in && rx_idx_reg == 6'h3f);
endmodule // apm_image_mapper

// [verif/apm_ctrl_model.sv]
// Controller-side model: takes input image beats, sends output image beats.
// Assumes the mapper's clock; the bench fills img and commands each image.
`timescale 1ns/100ps
module apm_ctrl_model (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic clear_in,
  input wire logic stall_in,
  input wire logic tx_valid_in,
  input wire logic [15:0] tx_data_in,
  input wire logic tx_last_in,
  output logic tx_ready_out,
  output logic rx_valid_out,
  output logic [15:0] rx_data_out,
  output logic rx_last_out,
  input wire logic rx_ready_in
);
  logic [15:0] got [0:63];
  logic [7:0] img [0:63];
  int n_got = 0;
  int last_at = -1;
  logic [1:0] cyc_reg = 2'h0;
  initial begin
    rx_valid_out = 1'b0;
    rx_data_out = 16'h0000;
    rx_last_out = 1'b0;
  end
  // Stalling holds ready low three cycles of four, so the buffer fills
  always @(posedge clk_in) begin
    cyc_reg <= cyc_reg + 2'h1;
    tx_ready_out <= rst_b_in && (!stall_in || cyc_reg == 2'h3);
    if (clear_in) begin
      n_got <= 0;
      last_at <= -1;
    end else if (tx_valid_in && tx_ready_out) begin
      got[n_got] <= tx_data_in;
      if (tx_last_in) last_at <= n_got;
      n_got <= n_got + 1;
    end
  end
  // Image spacing is left to the caller; the mapper does not police it
  task automatic send(input logic word, input int nbytes);
    int i;
    for (i = 0; i < nbytes; i += word ? 2 : 1) begin
      rx_valid_out <= 1'b1;
      rx_data_out <= word ? {img[i+1], img[i]} : {8'h00, img[i]};
      rx_last_out <= (i + (word ? 2 : 1)) >= nbytes;
      do @(posedge clk_in); while (rx_ready_in !== 1'b1);
    end
    rx_valid_out <= 1'b0;
    rx_last_out <= 1'b0;
    rx_data_out <= ~rx_data_out;
  endtask
endmodule // apm_ctrl_model

// [verif/tb.sv]
// Bench for the image mapper: streams images both ways and checks placement.
// Assumes apm_pkg and the controller model; slave inputs are static patterns.
`timescale 1ns/100ps
module tb
  import apm_pkg::*;
;
  logic clk_in = 1'b0;
  logic rst_b = 1'b0;
  logic dual_net = 1'b0, word_fmt = 1'b0, frame_start = 1'b0, stall_sel = 1'b0;
  logic [1:0] conn_type = 2'h0;
  logic [3:0] flags [0:1];
  logic [3:0] sa [0:1][0:31];
  logic [3:0] sb [0:1][0:31];
  logic [3:0] so_a [0:1][0:31];
  logic [3:0] so_b [0:1][0:31];
  logic tx_valid, tx_last, tx_ready, rx_valid, rx_last, rx_ready;
  logic [15:0] tx_data, rx_data;
  logic [8:0] in_len, out_len;
  logic [7:0] in_asm, out_asm;
  int err_count = 0;
  int samples_checked = 0;
  apm_image_mapper i_dut (.clk_in(clk_in), .rst_b_in(rst_b), .dual_net_in(dual_net), .word_fmt_in(word_fmt),
    .conn_type_in(conn_type), .frame_start_in(frame_start), .gw_flags_in(flags), .slave_in_a_in(sa),
    .slave_in_b_in(sb), .tx_valid_out(tx_valid), .tx_data_out(tx_data), .tx_last_out(tx_last),
    .tx_ready_in(tx_ready), .rx_valid_in(rx_valid), .rx_data_in(rx_data), .rx_last_in(rx_last),
    .rx_ready_out(rx_ready), .slave_out_a_out(so_a), .slave_out_b_out(so_b), .in_len_out(in_len),
    .out_len_out(out_len), .in_asm_out(in_asm), .out_asm_out(out_asm));
  apm_ctrl_model u_ctrl (.clk_in(clk_in), .rst_b_in(rst_b), .clear_in(frame_start), .stall_in(stall_sel),
    .tx_valid_in(tx_valid),
    .tx_data_in(tx_data), .tx_last_in(tx_last), .tx_ready_out(tx_ready), .rx_valid_out(rx_valid),
    .rx_data_out(rx_data), .rx_last_out(rx_last), .rx_ready_in(rx_ready));
  initial begin
    forever #4 clk_in = ~clk_in;
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  function automatic logic [7:0] exp_in(int i);
    int n, b, k;
    n = i / 32;
    b = i % 32;
    k = b % 16;
    if (b < 16) return {b == 0 ? flags[n] : sa[n][2*k], sa[n][2*k+1]};
    return {b == 16 ? 4'h0 : sb[n][2*k], sb[n][2*k+1]};
  endfunction
  function automatic logic [3:0] exp_out(int n, int isb, int a);
    logic [7:0] v;
    v = u_ctrl.img[n*32 + isb*16 + a/2];
    if (a == 0) return 4'h0;
    return a[0] ? v[3:0] : v[7:4];
  endfunction
  function automatic logic [8:0] exp_len(logic dual, logic out, logic [1:0] c);
    logic [8:0] v;
    if (out) v = c == 2'h2 ? APM_LEN_OUT_AIO : APM_LEN_DIG;
    else v = c == 2'h1 ? APM_LEN_IN_DIAG : (c == 2'h2 ? APM_LEN_IN_AIO : APM_LEN_DIG);
    return dual ? v << 1 : v;
  endfunction
  task automatic run_frame(input logic dual, input logic word, input logic [1:0] c, input logic stl);
    int nb, i;
    nb = (dual ? 64 : 32) / (word ? 2 : 1);
    @(posedge clk_in);
    dual_net <= dual;
    word_fmt <= word;
    conn_type <= c;
    stall_sel <= stl;
    frame_start <= 1'b1;
    @(posedge clk_in);
    frame_start <= 1'b0;
    @(posedge clk_in);
    for (i = 0; i < 4000 && u_ctrl.n_got < nb; i++) @(posedge clk_in);
    repeat (4) @(posedge clk_in);
    check("beat count", 16'(u_ctrl.n_got), 16'(nb));
    check("last beat", 16'(u_ctrl.last_at), 16'(nb - 1));
    for (i = 0; i < nb; i++) begin
      check("beat", u_ctrl.got[i], word ? {exp_in(2*i+1), exp_in(2*i)} : {8'h00, exp_in(i)});
    end
    check("in len", {7'h00, in_len}, {7'h00, exp_len(dual, 1'b0, c)});
    check("out len", {7'h00, out_len}, {7'h00, exp_len(dual, 1'b1, c)});
    check("in asm", {8'h00, in_asm},
      {8'h00, c == 2'h1 ? APM_ASM_IN_DIAG : c == 2'h2 ? APM_ASM_IN_AIO : APM_ASM_IN_DIG});
    check("out asm", {8'h00, out_asm}, {8'h00, c == 2'h2 ? APM_ASM_OUT_AIO : APM_ASM_OUT_DIG});
  endtask
  task automatic run_rx(input logic word, input int nets, input logic [7:0] seed);
    int i, n, a;
    for (i = 0; i < 64; i++) u_ctrl.img[i] = 8'(i * 29) ^ seed;
    @(posedge clk_in);
    word_fmt <= word;
    @(posedge clk_in);
    u_ctrl.send(word, nets * 32);
    repeat (2) @(posedge clk_in);
    for (n = 0; n < nets; n++) begin
      for (a = 0; a < 32; a++) begin
        check("out a", {12'h000, so_a[n][a]}, {12'h000, exp_out(n, 0, a)});
        check("out b", {12'h000, so_b[n][a]}, {12'h000, exp_out(n, 1, a)});
      end
    end
  endtask
  task automatic test_conn_types();
    int c;
    for (c = 0; c < 4; c++) run_frame(1'b0, 1'b0, 2'(c), c == 1);
    $display("test_conn_types done");
  endtask
  task automatic test_dual_images();
    run_frame(1'b1, 1'b1, 2'h2, 1'b1);
    run_frame(1'b1, 1'b0, 2'h0, 1'b0);
    run_frame(1'b0, 1'b1, 2'h1, 1'b0);
    $display("test_dual_images done");
  endtask
  task automatic test_rx_images();
    run_rx(1'b0, 1, 8'hf5);
    run_rx(1'b1, 2, 8'ha3);
    run_rx(1'b0, 2, 8'h5c);
    $display("test_rx_images done");
  endtask
  initial begin
    for (int n = 0; n < 2; n++) begin
      flags[n] = 4'(n * 6 + 9);
      for (int a = 0; a < 32; a++) begin
        sa[n][a] = 4'(a * 3 + n * 5 + 1);
        sb[n][a] = 4'(a * 7 + n * 11 + 4);
      end
    end
    repeat (12) @(posedge clk_in);
    check("reset ready", {15'h0000, rx_ready}, 16'h0000);
    check("reset len", {7'h00, in_len}, {7'h00, APM_LEN_DIG});
    rst_b <= 1'b1;
    repeat (2) @(posedge clk_in);
    check("ready after reset", {15'h0000, rx_ready}, 16'h0001);
    test_conn_types();
    test_dual_images();
    test_rx_images();
    wrap_up();
  end
  initial begin
    #200000;
    err_count++;
    wrap_up();
  end
endmodule // tb
